// file: hw/dcs_params.svh
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

`define DCS_OFF_OP 8'h40
`define DCS_OFF_STAT 8'h44
`define DCS_FLD_CTRL 2'h0
`define DCS_FLD_SRC 2'h1
`define DCS_FLD_DST 2'h2
`define DCS_FLD_CNT 2'h3

`define DCS_OP_DME 0
`define DCS_OP_PRI_LO 1

`define DCS_CTRL_EN 0
`define DCS_CTRL_AM_LO 1
`define DCS_CTRL_TM 3
`define DCS_CTRL_RS_LO 4
`define DCS_CTRL_DS 6
`define DCS_CTRL_SZ_LO 7

`define DCS_AM_DIRECT 2'h0
`define DCS_AM_INDIRECT 2'h1
`define DCS_AM_SGL_RD 2'h2
`define DCS_AM_SGL_WR 2'h3
`define DCS_RS_AUTO 2'h0
`define DCS_RS_EXT 2'h1
`define DCS_RS_PERIPH 2'h2
`define DCS_SZ_BYTE 2'h0
`define DCS_SZ_WORD 2'h1
`define DCS_SZ_LONG 2'h2

`define DCS_PRI_FIX0123 2'h0
`define DCS_PRI_FIX0231 2'h1
`define DCS_PRI_FIX2013 2'h2
`define DCS_PRI_RROBIN 2'h3

`define DCS_ONCHIP_TAG 4'hF
`define DCS_PTR_STEP 32'h0000_0004
`define DCS_RR_RESET_TOP 2'h0

`endif

// file: hw/dcs_pkg.sv
package dcs_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_BREQ = 7'h02,
        ST_SGL = 7'h04,
        ST_RD = 7'h08,
        ST_WR = 7'h10,
        ST_PTR = 7'h20,
        ST_NOP = 7'h40
    } dcs_state_t;

    typedef struct packed {
        dcs_state_t state;
        logic [1:0] ch;
        logic beat;
        logic hold;
        logic [1:0] rr_top;
        logic [1:0] pri_sel;
        logic dme;
        logic [3:0] err;
        logic [1:0] edge_pend;
        logic [3:0][8:0] ctrl;
        logic [3:0][31:0] src;
        logic [3:0][31:0] dst;
        logic [3:0][15:0] cnt;
        logic [31:0] data;
        logic [31:0] ptr;
        logic [31:0] rdata;
    } dcs_core_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } dcs_sync_t;

endpackage : dcs_pkg

// file: hw/dcs_req_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcs_params.svh"
module dcs_req_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] pin_n,
    output logic [1:0] req_level,
    output logic [1:0] req_fall
);
    dcs_pkg::dcs_sync_t q;
    dcs_pkg::dcs_sync_t next_q;

    // Pins idle high, so reset to the inactive level
    always_comb begin
        next_q.s1 = pin_n;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (!rst_n) begin
            next_q = '1;
        end
    end

    always_ff @(posedge clk) begin
        q <= next_q;
    end

    for (genvar g = 0; g < 2; g++) begin : g_pin
        assign req_level[g] = !q.s2[g];
        assign req_fall[g] = q.s3[g] && !q.s2[g];
    end
endmodule : dcs_req_sync
`default_nettype wire

// file: hw/dcs_arb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcs_params.svh"
module dcs_arb (
    input wire logic [3:0] pending,
    input wire logic [1:0] pri_sel,
    input wire logic [1:0] rr_top,
    output logic grant_valid,
    output logic [1:0] grant_ch
);
    function automatic logic [1:0] order_ch(input logic [1:0] sel, input logic [1:0] top,
                                            input logic [1:0] pos);
        case (sel)
            `DCS_PRI_FIX0123: order_ch = pos;
            `DCS_PRI_FIX0231: order_ch = (pos == 2'h0) ? 2'h0 : (pos == 2'h1) ? 2'h2 :
                                         (pos == 2'h2) ? 2'h3 : 2'h1;
            `DCS_PRI_FIX2013: order_ch = (pos == 2'h0) ? 2'h2 : (pos == 2'h1) ? 2'h0 :
                                         (pos == 2'h2) ? 2'h1 : 2'h3;
            default: order_ch = 2'(top + pos);
        endcase
    endfunction : order_ch

    // Walk from lowest rank up so the highest pending rank is the last to win
    always_comb begin
        grant_valid = 1'b0;
        grant_ch = 2'h0;
        for (int p = 3; p >= 0; p--) begin
            if (pending[order_ch(pri_sel, rr_top, 2'(p))]) begin
                grant_valid = 1'b1;
                grant_ch = order_ch(pri_sel, rr_top, 2'(p));
            end
        end
    end
endmodule : dcs_arb
`default_nettype wire

// file: hw/dcs_top.sv
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dcs_params.svh"
// What this block does
// - Among simultaneous requests exactly one channel is granted, per priority select.
// - Fixed orders 0-1-2-3, 0-2-3-1 and 2-0-1-3, highest first.
// - In round robin a channel finishing a unit drops to lowest.
// - After reset round robin order is 0,1,2,3.
// - Round robin rotates: channel after the finisher becomes highest.
// - Requests during a unit wait, then all pending re-arbitrate with new order.
// - Single address: one bus cycle, two for a 32-bit unit on a 16-bit bus, acknowledge strobe with the far address.
// - Single address only with both ends external; on-chip ends are refused.
// - Single address starts only from the external request pin.
// - Dual address drives both source and destination addresses.
// - Direct mode reads into a holding register, writes it next cycle.
// - Indirect on channel 3: fetch pointer, read data there, write destination.
// - Pointer is 32 bits; a 16-bit bus takes two reads for it.
// - One idle bus cycle between pointer fetch and using the pointer.
// - 32-bit indirect on a 16-bit bus splits data read and write too.
// - Each access lasts until the memory says ready, slow space included.
// - Each channel control register holds a cycle steal or burst bit.
// - Cycle steal releases the bus after every unit.
// - Burst keeps the bus until no request, level pin release included.
module dcs_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [1:0] external_transfer_request_n,
    input wire logic [3:0] periph_req,
    input wire logic bus_width16,
    output logic bus_req,
    input wire logic bus_grant,
    output logic bus_valid,
    output logic bus_write,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic [1:0] bus_size,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ready,
    output logic [1:0] transfer_acknowledge_strobe
);
    dcs_pkg::dcs_core_t core;
    dcs_pkg::dcs_core_t next_core;
    logic [1:0] ext_level;
    logic [1:0] ext_fall;
    logic [3:0] pending;
    logic [3:0] err_set;
    logic grant_valid;
    logic [1:0] grant_ch;
    logic [8:0] cur_ctrl;
    logic [1:0] cur_mode;
    logic [1:0] cur_sz;
    logic two_beats;
    logic last_beat;
    logic acc_state;
    logic step_done;
    logic unit_done;

    function automatic logic is_chan_reg(input logic [7:0] a);
        is_chan_reg = (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
    endfunction : is_chan_reg

    function automatic dcs_pkg::dcs_state_t first_state(input logic [1:0] mode);
        case (mode)
            `DCS_AM_DIRECT: first_state = dcs_pkg::ST_RD;
            `DCS_AM_INDIRECT: first_state = dcs_pkg::ST_PTR;
            default: first_state = dcs_pkg::ST_SGL;
        endcase
    endfunction : first_state

    function automatic logic [31:0] sz_bytes(input logic [1:0] sz);
        case (sz)
            `DCS_SZ_BYTE: sz_bytes = 32'h0000_0001;
            `DCS_SZ_WORD: sz_bytes = 32'h0000_0002;
            default: sz_bytes = 32'h0000_0004;
        endcase
    endfunction : sz_bytes

    dcs_req_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_n(external_transfer_request_n),
        .req_level(ext_level),
        .req_fall(ext_fall)
    );

    dcs_arb u_arb (
        .pending(pending),
        .pri_sel(core.pri_sel),
        .rr_top(core.rr_top),
        .grant_valid(grant_valid),
        .grant_ch(grant_ch)
    );

    assign cur_ctrl = core.ctrl[core.ch];
    assign cur_mode = cur_ctrl[`DCS_CTRL_AM_LO +: 2];
    assign cur_sz = cur_ctrl[`DCS_CTRL_SZ_LO +: 2];
    // The pointer is always a full word, whatever the unit size
    assign two_beats = bus_width16 &&
                       (core.state == dcs_pkg::ST_PTR || cur_sz == `DCS_SZ_LONG);
    assign last_beat = !two_beats || core.beat;
    assign acc_state = (core.state == dcs_pkg::ST_SGL) || (core.state == dcs_pkg::ST_RD) ||
                       (core.state == dcs_pkg::ST_WR) || (core.state == dcs_pkg::ST_PTR);
    assign step_done = acc_state && bus_ready && last_beat;
    assign unit_done = step_done &&
                       (core.state == dcs_pkg::ST_WR || core.state == dcs_pkg::ST_SGL);

    // Channel qualification; illegal setups raise an error instead of running
    always_comb begin
        logic [8:0] cc;
        logic en;
        logic sgl;
        logic ok;
        logic req;
        logic [31:0] far;
        cc = 9'h000;
        en = 1'b0;
        sgl = 1'b0;
        ok = 1'b0;
        req = 1'b0;
        far = 32'h0000_0000;
        pending = 4'h0;
        err_set = 4'h0;
        for (int c = 0; c < 4; c++) begin
            cc = core.ctrl[c];
            en = cc[`DCS_CTRL_EN] && core.dme && (core.cnt[c] != 16'h0000) && !core.err[c];
            sgl = cc[`DCS_CTRL_AM_LO + 1];
            far = (cc[`DCS_CTRL_AM_LO +: 2] == `DCS_AM_SGL_RD) ? core.src[c] : core.dst[c];
            ok = 1'b1;
            if (sgl && (c > 1 || cc[`DCS_CTRL_RS_LO +: 2] != `DCS_RS_EXT)) begin
                ok = 1'b0;
            end
            if (sgl && far[31:28] == `DCS_ONCHIP_TAG) begin
                ok = 1'b0;
            end
            if (cc[`DCS_CTRL_AM_LO +: 2] == `DCS_AM_INDIRECT && c != 3) begin
                ok = 1'b0;
            end
            case (cc[`DCS_CTRL_RS_LO +: 2])
                `DCS_RS_AUTO: req = 1'b1;
                `DCS_RS_EXT: req = (c < 2) && (cc[`DCS_CTRL_DS] ? core.edge_pend[c[0]]
                                                                : ext_level[c[0]]);
                `DCS_RS_PERIPH: req = periph_req[c];
                default: req = 1'b0;
            endcase
            err_set[c] = en && !ok;
            pending[c] = en && ok && req;
        end
    end

    always_comb begin
        next_core = core;
        next_core.rdata = 32'h0000_0000;
        if (reg_wr) begin
            if (is_chan_reg(reg_addr)) begin
                case (reg_addr[3:2])
                    `DCS_FLD_CTRL: begin
                        next_core.ctrl[reg_addr[5:4]] = reg_wdata[8:0];
                        next_core.err[reg_addr[5:4]] = 1'b0;
                    end
                    `DCS_FLD_SRC: next_core.src[reg_addr[5:4]] = reg_wdata;
                    `DCS_FLD_DST: next_core.dst[reg_addr[5:4]] = reg_wdata;
                    default: next_core.cnt[reg_addr[5:4]] = reg_wdata[15:0];
                endcase
            end else if (reg_addr == `DCS_OFF_OP) begin
                next_core.dme = reg_wdata[`DCS_OP_DME];
                next_core.pri_sel = reg_wdata[`DCS_OP_PRI_LO +: 2];
            end
        end
        if (reg_rd) begin
            if (is_chan_reg(reg_addr)) begin
                case (reg_addr[3:2])
                    `DCS_FLD_CTRL: next_core.rdata = {23'h000000, core.ctrl[reg_addr[5:4]]};
                    `DCS_FLD_SRC: next_core.rdata = core.src[reg_addr[5:4]];
                    `DCS_FLD_DST: next_core.rdata = core.dst[reg_addr[5:4]];
                    default: next_core.rdata = {16'h0000, core.cnt[reg_addr[5:4]]};
                endcase
            end else if (reg_addr == `DCS_OFF_OP) begin
                next_core.rdata = {29'h00000000, core.pri_sel, core.dme};
            end else if (reg_addr == `DCS_OFF_STAT) begin
                next_core.rdata = {19'h00000, core.state != dcs_pkg::ST_IDLE, core.ch,
                                   core.rr_top, pending, core.err};
            end
        end
        // Hardware events land after the software clear so a same-cycle set wins
        next_core.err = next_core.err | err_set;
        if (acc_state && bus_ready && !last_beat) begin
            next_core.beat = 1'b1;
        end
        if (step_done) begin
            next_core.beat = 1'b0;
        end
        case (core.state)
            dcs_pkg::ST_IDLE: begin
                if (grant_valid) begin
                    next_core.ch = grant_ch;
                    next_core.beat = 1'b0;
                    if (core.hold && bus_grant) begin
                        next_core.state = first_state(core.ctrl[grant_ch][`DCS_CTRL_AM_LO +: 2]);
                    end else begin
                        next_core.state = dcs_pkg::ST_BREQ;
                    end
                end else begin
                    next_core.hold = 1'b0;
                end
            end
            dcs_pkg::ST_BREQ: begin
                if (bus_grant) begin
                    next_core.state = first_state(cur_mode);
                end
            end
            dcs_pkg::ST_PTR: begin
                if (bus_ready) begin
                    if (two_beats && !core.beat) begin
                        next_core.ptr[31:16] = bus_rdata[15:0];
                    end else if (two_beats) begin
                        next_core.ptr[15:0] = bus_rdata[15:0];
                    end else begin
                        next_core.ptr = bus_rdata;
                    end
                end
                if (step_done) begin
                    next_core.state = dcs_pkg::ST_NOP;
                end
            end
            dcs_pkg::ST_NOP: next_core.state = dcs_pkg::ST_RD;
            dcs_pkg::ST_RD: begin
                if (bus_ready) begin
                    if (two_beats && !core.beat) begin
                        next_core.data[31:16] = bus_rdata[15:0];
                    end else if (two_beats) begin
                        next_core.data[15:0] = bus_rdata[15:0];
                    end else begin
                        next_core.data = bus_rdata;
                    end
                end
                if (step_done) begin
                    next_core.state = dcs_pkg::ST_WR;
                end
            end
            dcs_pkg::ST_WR, dcs_pkg::ST_SGL: begin
                if (unit_done) begin
                    next_core.state = dcs_pkg::ST_IDLE;
                    next_core.cnt[core.ch] = core.cnt[core.ch] - 16'h0001;
                    if (cur_mode == `DCS_AM_INDIRECT) begin
                        next_core.src[core.ch] = core.src[core.ch] + `DCS_PTR_STEP;
                    end else if (cur_mode != `DCS_AM_SGL_WR) begin
                        next_core.src[core.ch] = core.src[core.ch] + sz_bytes(cur_sz);
                    end
                    if (cur_mode != `DCS_AM_SGL_RD) begin
                        next_core.dst[core.ch] = core.dst[core.ch] + sz_bytes(cur_sz);
                    end
                    if (core.pri_sel == `DCS_PRI_RROBIN) begin
                        next_core.rr_top = 2'(core.ch + 2'h1);
                    end
                    if (!core.ch[1]) begin
                        next_core.edge_pend[core.ch[0]] = 1'b0;
                    end
                    // Cycle steal gives the bus back; burst keeps it while requests last
                    next_core.hold = cur_ctrl[`DCS_CTRL_TM];
                end
            end
            default: next_core.state = dcs_pkg::ST_IDLE;
        endcase
        next_core.edge_pend = next_core.edge_pend | ext_fall;
        if (!rst_n) begin
            next_core = '0;
            next_core.state = dcs_pkg::ST_IDLE;
            next_core.rr_top = `DCS_RR_RESET_TOP;
        end
    end

    always_ff @(posedge clk) begin
        core <= next_core;
    end

    always_comb begin
        bus_write = 1'b0;
        bus_size = (core.state == dcs_pkg::ST_PTR) ? `DCS_SZ_LONG : cur_sz;
        transfer_acknowledge_strobe = 2'h0;
        case (core.state)
            dcs_pkg::ST_SGL: begin
                // The far end sees only an address; the peripheral moves the data
                bus_addr = (cur_mode == `DCS_AM_SGL_RD) ? core.src[core.ch] : core.dst[core.ch];
                bus_write = (cur_mode == `DCS_AM_SGL_WR);
                transfer_acknowledge_strobe[core.ch[0]] = 1'b1;
            end
            dcs_pkg::ST_PTR: bus_addr = core.src[3];
            dcs_pkg::ST_RD: bus_addr = (cur_mode == `DCS_AM_INDIRECT) ? core.ptr
                                                                     : core.src[core.ch];
            dcs_pkg::ST_WR: begin
                bus_addr = core.dst[core.ch];
                bus_write = 1'b1;
            end
            default: bus_addr = 32'h0000_0000;
        endcase
        bus_addr = bus_addr + {30'h00000000, core.beat, 1'b0};
    end

    assign bus_wdata = !two_beats ? core.data :
                       core.beat ? {16'h0000, core.data[15:0]} : {16'h0000, core.data[31:16]};
    assign bus_valid = acc_state;
    assign bus_req = (core.state != dcs_pkg::ST_IDLE) || core.hold;
    assign reg_rdata = core.rdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ptr_done;
        core.state == dcs_pkg::ST_PTR && step_done;
    endsequence
    sequence s_nop_then_read;
        core.state == dcs_pkg::ST_NOP ##1 core.state == dcs_pkg::ST_RD;
    endsequence

    a_grant_pending: assert property (grant_valid |-> pending[grant_ch])
        else $error("grant to a channel without a request");
    a_fixed_ch0: assert property (core.pri_sel == `DCS_PRI_FIX0231 && pending[0]
                                  |-> grant_ch == 2'h0)
        else $error("fixed order lost channel 0 first place");
    a_fixed_ch2: assert property (core.pri_sel == `DCS_PRI_FIX2013 && pending[2]
                                  |-> grant_ch == 2'h2)
        else $error("fixed order lost channel 2 first place");
    a_rr_rotate: assert property (unit_done && core.pri_sel == `DCS_PRI_RROBIN
                                  |=> core.rr_top == 2'($past(core.ch) + 2'h1))
        else $error("round robin did not rotate past finisher");
    a_rr_reset: assert property (disable iff (1'b0) !rst_n |=> core.rr_top == 2'h0)
        else $error("round robin order not restored by reset");
    a_single_ack: assert property (core.state == dcs_pkg::ST_SGL
                                   |-> $onehot(transfer_acknowledge_strobe) && bus_valid)
        else $error("single cycle without acknowledge strobe");
    a_single_src: assert property (core.state == dcs_pkg::ST_SGL |-> !core.ch[1] &&
                   cur_ctrl[`DCS_CTRL_RS_LO +: 2] == `DCS_RS_EXT)
        else $error("single address started from wrong source");
    a_direct_wr: assert property (core.state == dcs_pkg::ST_RD && step_done
                                  |=> core.state == dcs_pkg::ST_WR && bus_write)
        else $error("read not followed by write");
    a_nop_gap: assert property (s_ptr_done |=> s_nop_then_read)
        else $error("pointer use without one idle cycle");
    a_ptr_split: assert property (core.state == dcs_pkg::ST_PTR && bus_width16 && bus_ready &&
                                  !core.beat |=> core.state == dcs_pkg::ST_PTR)
        else $error("pointer fetch not split on narrow bus");
    a_steal_drop: assert property (unit_done && !cur_ctrl[`DCS_CTRL_TM] |=> !bus_req)
        else $error("cycle steal kept the bus");
endmodule : dcs_top
`default_nettype wire

// file: test/dcs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcs_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_req,
    output logic bus_grant,
    input wire logic bus_valid,
    input wire logic [31:0] bus_addr,
    input wire logic bus_width16,
    input wire logic [1:0] slow,
    output logic [31:0] bus_rdata,
    output logic bus_ready
);
    logic [1:0] cnt;
    logic [31:0] word;
    // Word content is its address plus an offset, so a fetched pointer lands in open space
    assign word = {bus_addr[31:2], 2'b00} + 32'h1234_1000;
    // Outside a ready beat the data are inverted, so a stale sample never looks right
    assign bus_rdata = !bus_ready ? ~word : (!bus_width16 ? word :
        {16'h0000, bus_addr[1] ? word[15:0] : word[31:16]});
    // The acknowledged peripheral moves its data in the same ready beat
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_grant <= 1'b0;
            bus_ready <= 1'b0;
            cnt <= 2'h0;
        end else begin
            bus_grant <= bus_req;
            bus_ready <= bus_valid && !bus_ready && cnt == slow;
            cnt <= (bus_valid && !bus_ready && cnt != slow) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule : dcs_mem_model
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module testbench;
    logic clk, rst_n, reg_wr, reg_rd, w16, bus_req, bus_grant, bus_valid, bus_write, bus_ready;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata;
    logic [1:0] pin_n, bus_size, ack, slow;
    logic [3:0] preq;
    logic q_wr[$];
    logic [31:0] q_addr[$], q_dat[$];
    logic [3:0] q_ack[$];
    int q_gap[$];
    int num_errors = 0, tests_run = 0, gap = 0, falls = 0;
    logic req_d = 1'b0;
    int ord [3][4] = '{'{0, 1, 2, 3}, '{0, 2, 3, 1}, '{2, 0, 1, 3}};
    dcs_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_transfer_request_n(pin_n), .periph_req(preq), .bus_width16(w16),
        .bus_req(bus_req), .bus_grant(bus_grant), .bus_valid(bus_valid), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_rdata(bus_rdata),
        .bus_ready(bus_ready), .transfer_acknowledge_strobe(ack));
    dcs_mem_model mem (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_grant(bus_grant),
        .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_width16(w16), .slow(slow),
        .bus_rdata(bus_rdata), .bus_ready(bus_ready));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Log every completed beat with the idle run before it
    always @(posedge clk) if (rst_n) begin
        if (bus_valid && bus_ready) begin
            q_wr.push_back(bus_write);
            q_addr.push_back(bus_addr);
            q_dat.push_back(bus_write ? bus_wdata : bus_rdata);
            q_ack.push_back({bus_size, ack});
            q_gap.push_back(gap);
            gap = 0;
        end else if (!bus_valid) gap++;
        if (req_d && !bus_req) falls++;
        req_d = bus_req;
    end
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[31:2], 2'b00} + 32'h1234_1000;
    endfunction : pat
    function automatic logic [31:0] ctl(input int mode, tm, rs);
        return {23'h0, 2'h2, 1'b0, 2'(rs), 1'(tm), 2'(mode), 1'b1};
    endfunction : ctl
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        q_wr.delete();
        q_addr.delete();
        q_dat.delete();
        q_ack.delete();
        q_gap.delete();
        falls = 0;
        req_d = 1'b0;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chan(input int c, input logic [31:0] cw, src, dst, cnt);
        wr(8'(16 * c + 4), src);
        wr(8'(16 * c + 8), dst);
        wr(8'(16 * c + 12), cnt);
        wr(8'(16 * c), cw);
    endtask : chan
    task automatic wait_acc(input int n);
        for (int i = 0; i < 3000 && q_addr.size() < n; i++) @(posedge clk);
        repeat (30) @(posedge clk);
        `CHK("beat count", n, q_addr.size())
    endtask : wait_acc
    task automatic unit(input int k, input logic [31:0] src);
        `CHK("read address", src, q_addr[2 * k])
        `CHK("write flag", 1'b1, q_wr[2 * k + 1])
        `CHK("write data", pat(src), q_dat[2 * k + 1])
    endtask : unit
    task automatic t_regs();
        logic [31:0] d;
        do_reset();
        rd(8'h44, d);
        `CHK("rr top", 2'h0, d[9:8])
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, d);
        `CHK("unmapped", 32'h0, d)
        wr(8'h40, 32'h6);
        rd(8'h40, d);
        `CHK("op register", 32'h6, d)
    endtask : t_regs
    task automatic t_fixed();
        for (int p = 0; p < 3; p++) begin
            do_reset();
            for (int c = 0; c < 4; c++) chan(c, ctl(0, 0, 0), 32'h1000 * (c + 1), 32'h20000, 1);
            wr(8'h40, 32'(2 * p + 1));
            wait_acc(8);
            for (int u = 0; u < 4; u++) unit(u, 32'h1000 * (ord[p][u] + 1));
        end
    endtask : t_fixed
    task automatic t_rr();
        do_reset();
        preq <= 4'hF;
        for (int c = 0; c < 4; c++) chan(c, ctl(0, 0, 2), 32'h1000 * (c + 1), 32'h20000, 2);
        wr(8'h40, 32'h7);
        wait_acc(16);
        for (int k = 0; k < 8; k++) unit(k, 32'h1000 * (k % 4 + 1) + 4 * (k / 4));
        preq <= 4'h0;
    endtask : t_rr
    task automatic t_rot();
        logic [31:0] d;
        do_reset();
        slow <= 2'h3;
        chan(0, ctl(0, 0, 0), 32'h1000, 32'h20000, 1);
        chan(3, ctl(0, 0, 0), 32'h4000, 32'h20000, 1);
        wr(8'h40, 32'h7);
        for (int i = 0; i < 200 && !bus_valid; i++) @(posedge clk);
        chan(1, ctl(0, 0, 0), 32'h2000, 32'h20000, 1);
        wait_acc(6);
        unit(0, 32'h1000);
        unit(1, 32'h2000);
        unit(2, 32'h4000);
        rd(8'h44, d);
        `CHK("rr top", 2'h0, d[9:8])
        slow <= 2'h0;
    endtask : t_rot
    task automatic t_ind();
        logic [31:0] ea[6] = '{32'h2000, 32'h2002, 32'h1234_3000, 32'h1234_3002, 32'h5_0000,
            32'h5_0002};
        do_reset();
        w16 <= 1'b1;
        chan(3, ctl(1, 0, 0), 32'h2000, 32'h5_0000, 1);
        wr(8'h40, 32'h1);
        wait_acc(6);
        for (int k = 0; k < 6; k++) `CHK("indirect beat", ea[k], q_addr[k])
        `CHK("idle cycle", 1, q_gap[2])
        `CHK("high half", 16'h2468, q_dat[4][15:0])
        `CHK("low half", 16'h4000, q_dat[5][15:0])
        w16 <= 1'b0;
    endtask : t_ind
    task automatic t_single();
        for (int c = 0; c < 2; c++) begin
            do_reset();
            chan(c, ctl(2 + c, 0, 1), 32'h6000, 32'h7000, 1);
            wr(8'h40, 32'h1);
            pin_n[c] <= 1'b0;
            wait_acc(1);
            pin_n <= 2'b11;
            `CHK("ack", 2'(1 << c), q_ack[0][1:0])
            `CHK("unit size", 2'h2, q_ack[0][3:2])
            `CHK("far address", c ? 32'h7000 : 32'h6000, q_addr[0])
            `CHK("direction", 1'(c), q_wr[0])
        end
    endtask : t_single
    task automatic t_refuse();
        int cs[3] = '{2, 0, 0};
        int rs[3] = '{1, 0, 1};
        logic [31:0] d;
        for (int k = 0; k < 3; k++) begin
            do_reset();
            chan(cs[k], ctl(2, 0, rs[k]), k == 2 ? 32'hF000_0000 : 32'h6000, 32'h7000, 1);
            wr(8'h40, 32'h1);
            pin_n <= 2'b00;
            repeat (50) @(posedge clk);
            pin_n <= 2'b11;
            `CHK("refused beats", 0, q_addr.size())
            rd(8'h44, d);
            `CHK("error bit", 1'b1, d[cs[k]])
        end
    endtask : t_refuse
    task automatic t_bus();
        for (int tm = 0; tm < 2; tm++) begin
            do_reset();
            slow <= 2'h3;
            chan(0, ctl(0, tm, 0), 32'h1000, 32'h20000, 2);
            wr(8'h40, 32'h1);
            wait_acc(4);
            `CHK("bus releases", 2 - tm, falls)
        end
        slow <= 2'h0;
    endtask : t_bus
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    initial begin
        {rst_n, reg_wr, reg_rd, w16, reg_addr, reg_wdata, slow, preq} = '0;
        pin_n = 2'b11;
        t_regs();
        t_fixed();
        t_rr();
        t_rot();
        t_ind();
        t_single();
        t_refuse();
        t_bus();
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
